// file: hw/bbc_defines.svh
// constants for the bit, branch and call execution slice
// Notes on behaviour
// - bit clear zeroes bit b of file f, nothing else changes
// - bit set forces bit b of file f to one, nothing else
// - literal branch: pc plus one plus sign-extended 9-bit literal, two cycles
// - accumulator branch: pc plus one plus unsigned accumulator, two cycles
// - skip-if-zero: bit zero squashes next instruction, two cycles
// - skip-if-one: bit one squashes next instruction, two cycles
// - call pushes pc plus one onto stack on the same edge that changes pc
// - call loads 11-bit immediate into pc bits 10 to 0
// - call fills pc bits 14 to 11 from page latch bits 6 to 3
// - call takes two cycles, second flushes fetch, flags untouched
`ifndef BBC_DEFINES_SVH
`define BBC_DEFINES_SVH
`define BBC_PC_W 15
`define BBC_PC_RST 15'h0000
`define BBC_FADDR_W 7
`define BBC_REL_W 9
`define BBC_CALL_W 11
`define BBC_PAGE_MSB 6
`define BBC_PAGE_LSB 3
`define BBC_SEQ_STEP 15'h0001
`define BBC_SKIP_STEP 15'h0002
`endif

// file: hw/bbc_pkg.sv
// types for the bit, branch and call execution slice
`include "bbc_defines.svh"
package bbc_pkg;
  // operation select from the decoder
  typedef enum logic [2:0] {
    op_none = 3'h0,
    bit_clear_op = 3'h1,
    bit_set_op = 3'h2,
    rel_jump_literal_op = 3'h3,
    rel_jump_acc_op = 3'h4,
    test_skip_if_zero_op = 3'h5,
    test_skip_if_one_op = 3'h6,
    call_op = 3'h7
  } bbc_op_t;

  // execution state, one-hot
  typedef enum logic [1:0] {
    st_exec = 2'b01,
    st_flush = 2'b10
  } bbc_fsm_t;

  // all registered state of the slice
  typedef struct packed {
    bbc_fsm_t fsm;
    logic [`BBC_PC_W-1:0] pc;
    logic we;
    logic [`BBC_FADDR_W-1:0] waddr;
    logic [7:0] wdata;
    logic push;
    logic [`BBC_PC_W-1:0] stack_top_entry;
    logic flush;
    logic retire;
  } bbc_state_t;
endpackage : bbc_pkg

// file: hw/bbc_exec.sv
// execution of bit clear/set, bit test skip, relative branches and call
`timescale 1ns/1ns
`include "bbc_defines.svh"
module bbc_exec (
  input wire logic clock,
  input wire logic rst,
  input wire logic instr_valid,
  input wire bbc_pkg::bbc_op_t instr_op,
  input wire logic [`BBC_FADDR_W-1:0] file_addr,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] file_rdata,
  input wire logic [`BBC_REL_W-1:0] rel_lit,
  input wire logic [`BBC_CALL_W-1:0] call_lit,
  input wire logic [7:0] acc,
  input wire logic [7:0] page_latch_reg,
  output logic [`BBC_PC_W-1:0] pc_q,
  output logic file_we_q,
  output logic [`BBC_FADDR_W-1:0] file_waddr_q,
  output logic [7:0] file_wdata_q,
  output logic stack_push_q,
  output logic [`BBC_PC_W-1:0] stack_top_entry_q,
  output logic flush_q,
  output logic retire_q
);

  // ==========================================================
  // overview
  // one instruction may be taken on each rising edge while the slice sits in
  // the execute state; every effect shows on the outputs right after the taking edge.
  // two-cycle instructions (branches, call, a taken skip) move to the flush
  // state, and whatever the core presents in that cycle is dropped.
  // file writes are read-modify-write: file_rdata must already hold the
  // addressed register in the cycle the instruction is presented.
  // a taken skip steps the pc over the squashed word at once and then holds
  // it through the flush cycle, so the core fetches from the right place.
  // pc arithmetic is plain modulo 2**15; no flag or error leaves the slice.
  // the return address pushed by a call is the word after the call itself.
  // page_latch_reg is sampled in the cycle the call is taken.

  // ==========================================================
  // decode helpers
  bbc_pkg::bbc_state_t s_q;
  bbc_pkg::bbc_state_t s_d;
  logic accept;
  logic [7:0] bit_mask;
  logic bit_val;
  logic [`BBC_PC_W-1:0] pc_inc;
  logic [`BBC_PC_W-1:0] rel_ext;
  logic [`BBC_PC_W-1:0] acc_ext;

  // an instruction is taken only outside the flush cycle
  assign accept = instr_valid && (s_q.fsm == bbc_pkg::st_exec);
  assign bit_mask = 8'h01 << bit_sel;
  assign bit_val = |(file_rdata & bit_mask);
  assign pc_inc = s_q.pc + `BBC_SEQ_STEP;
  // signed literal widened to pc width
  assign rel_ext = {{(`BBC_PC_W-`BBC_REL_W){rel_lit[`BBC_REL_W-1]}}, rel_lit};
  // accumulator taken as unsigned
  assign acc_ext = {{(`BBC_PC_W-8){1'b0}}, acc};

  // ==========================================================
  // next state
  always_comb begin
    // hold everything, pulses fall back to zero
    s_d = s_q;
    s_d.we = 1'b0;
    s_d.push = 1'b0;
    s_d.flush = 1'b0;
    s_d.retire = 1'b0;
    case (s_q.fsm)
      bbc_pkg::st_exec: begin
        if (accept) begin
          // accepted: retire pulse and sequential pc by default
          s_d.retire = 1'b1;
          s_d.pc = pc_inc;
          case (instr_op)
            bbc_pkg::bit_clear_op: begin
              // read-modify-write of the whole register
              s_d.we = 1'b1;
              s_d.waddr = file_addr;
              s_d.wdata = file_rdata & ~bit_mask;
            end
            bbc_pkg::bit_set_op: begin
              // same read-modify-write, selected bit forced high
              s_d.we = 1'b1;
              s_d.waddr = file_addr;
              s_d.wdata = file_rdata | bit_mask;
            end
            bbc_pkg::rel_jump_literal_op: begin
              // signed offset from the incremented pc, fetch redirected
              s_d.pc = pc_inc + rel_ext;
              s_d.fsm = bbc_pkg::st_flush;
              s_d.flush = 1'b1;
            end
            bbc_pkg::rel_jump_acc_op: begin
              // unsigned accumulator offset from the incremented pc
              s_d.pc = pc_inc + acc_ext;
              s_d.fsm = bbc_pkg::st_flush;
              s_d.flush = 1'b1;
            end
            bbc_pkg::test_skip_if_zero_op: begin
              if (!bit_val) begin
                // step over the squashed instruction
                s_d.pc = s_q.pc + `BBC_SKIP_STEP;
                s_d.fsm = bbc_pkg::st_flush;
                s_d.flush = 1'b1;
              end
            end
            bbc_pkg::test_skip_if_one_op: begin
              if (bit_val) begin
                // bit one: step over the squashed instruction
                s_d.pc = s_q.pc + `BBC_SKIP_STEP;
                s_d.fsm = bbc_pkg::st_flush;
                s_d.flush = 1'b1;
              end
            end
            bbc_pkg::call_op: begin
              // return address captured from the old pc
              s_d.push = 1'b1;
              s_d.stack_top_entry = pc_inc;
              s_d.pc = {page_latch_reg[`BBC_PAGE_MSB:`BBC_PAGE_LSB], call_lit};
              s_d.fsm = bbc_pkg::st_flush;
              s_d.flush = 1'b1;
            end
            default: begin
              // no-operation code only moves the pc on
              s_d.pc = pc_inc;
            end
          endcase
        end
      end
      bbc_pkg::st_flush: begin
        // second cycle: the fetched word is dropped and the pc holds
        s_d.fsm = bbc_pkg::st_exec;
      end
      default: begin
        s_d.fsm = bbc_pkg::st_exec;
      end
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '{fsm: bbc_pkg::st_exec, pc: `BBC_PC_RST, we: 1'b0,
               waddr: '0, wdata: 8'h00, push: 1'b0, stack_top_entry: `BBC_PC_RST,
               flush: 1'b0, retire: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state flops
  assign pc_q = s_q.pc;
  assign file_we_q = s_q.we;
  assign file_waddr_q = s_q.waddr;
  assign file_wdata_q = s_q.wdata;
  assign stack_push_q = s_q.push;
  assign stack_top_entry_q = s_q.stack_top_entry;
  assign flush_q = s_q.flush;
  assign retire_q = s_q.retire;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // one strobe per instruction kind, as taken
  logic take_clr;
  logic take_set;
  logic take_bra;
  logic take_brw;
  logic take_skz;
  logic take_sko;
  logic take_call;
  assign take_clr = accept && (instr_op == bbc_pkg::bit_clear_op);
  assign take_set = accept && (instr_op == bbc_pkg::bit_set_op);
  assign take_bra = accept && (instr_op == bbc_pkg::rel_jump_literal_op);
  assign take_brw = accept && (instr_op == bbc_pkg::rel_jump_acc_op);
  assign take_skz = accept && (instr_op == bbc_pkg::test_skip_if_zero_op);
  assign take_sko = accept && (instr_op == bbc_pkg::test_skip_if_one_op);
  assign take_call = accept && (instr_op == bbc_pkg::call_op);

  chk_clear_bit_rmw: assert property (
    take_clr |=> file_we_q && file_waddr_q == $past(file_addr)
      && file_wdata_q == ($past(file_rdata) & ~$past(bit_mask)))
    else $error("bit clear wrote wrong value");

  chk_set_bit_rmw: assert property (
    take_set |=> file_we_q && file_waddr_q == $past(file_addr)
      && file_wdata_q == ($past(file_rdata) | $past(bit_mask)))
    else $error("bit set wrote wrong value");

  chk_lit_branch_target: assert property (
    take_bra |=> pc_q == $past(pc_q) + `BBC_SEQ_STEP + $past(rel_ext)
      ##1 pc_q == $past(pc_q) && !retire_q)
    else $error("literal branch target or timing wrong");

  chk_acc_branch_target: assert property (
    take_brw |=> flush_q && pc_q == $past(pc_q) + `BBC_SEQ_STEP + $past(acc_ext)
      ##1 !flush_q && !retire_q)
    else $error("accumulator branch target or timing wrong");

  chk_skip_zero: assert property (
    take_skz |=> (flush_q == !$past(bit_val)) && (pc_q == ($past(bit_val) ?
      $past(pc_q) + `BBC_SEQ_STEP : $past(pc_q) + `BBC_SKIP_STEP)))
    else $error("skip if zero misbehaved");

  chk_skip_one: assert property (
    take_sko |=> (flush_q == $past(bit_val)) && (pc_q == ($past(bit_val) ?
      $past(pc_q) + `BBC_SKIP_STEP : $past(pc_q) + `BBC_SEQ_STEP)))
    else $error("skip if one misbehaved");

  chk_call_push: assert property (
    take_call |=> stack_push_q && stack_top_entry_q == $past(pc_q) + `BBC_SEQ_STEP
      ##1 !stack_push_q)
    else $error("call return address wrong");

  chk_call_low: assert property (
    take_call |=> pc_q[`BBC_CALL_W-1:0] == $past(call_lit))
    else $error("call low pc bits wrong");

  chk_call_page: assert property (
    take_call |=> pc_q[`BBC_PC_W-1:`BBC_CALL_W]
      == $past(page_latch_reg[`BBC_PAGE_MSB:`BBC_PAGE_LSB]))
    else $error("call page bits wrong");

  chk_call_two_cycle: assert property (
    take_call |=> flush_q && !file_we_q ##1 !flush_q && !retire_q)
    else $error("call did not flush for one cycle");

  chk_single_cycle: assert property (
    (take_clr || take_set) |=> retire_q && !flush_q && s_q.fsm == bbc_pkg::st_exec)
    else $error("bit write not single cycle");

  chk_pc_wraps: assert property (
    (take_bra && pc_q == 15'h7fff && rel_lit == 9'h000) |=> pc_q == 15'h0000)
    else $error("branch did not wrap");

  // instructions that are not bit writes never strobe the file
  chk_no_stray_write: assert property (
    !(take_clr || take_set) |=> !file_we_q)
    else $error("file written by a non-writing instruction");

  chk_write_regs_hold: assert property (
    !(take_clr || take_set) |=> $stable(file_waddr_q) && $stable(file_wdata_q))
    else $error("write address or data moved without a write");

  // branches leave the file and the stack alone
  chk_branch_no_side: assert property (
    (take_bra || take_brw) |=> !file_we_q && !stack_push_q && retire_q)
    else $error("branch touched file or stack");

  // the accumulator offset never moves the pc backwards unless the sum wraps past 7fff
  chk_acc_forward: assert property (
    (take_brw && pc_q < 15'h7e00) |=> pc_q > $past(pc_q))
    else $error("accumulator branch moved backwards");

  // a test retires without writing or pushing
  chk_test_no_side: assert property (
    (take_skz || take_sko) |=> retire_q && !file_we_q && !stack_push_q)
    else $error("bit test had a side effect");

  // a bit test that does not skip lets the next word in at once
  chk_test_no_skip: assert property (
    ((take_skz && bit_val) || (take_sko && !bit_val)) |=> !flush_q
      && s_q.fsm == bbc_pkg::st_exec)
    else $error("bit test stalled without a skip");

  // only a call pushes, and the return address holds until the next call
  chk_push_only_call: assert property (
    !take_call |=> !stack_push_q && $stable(stack_top_entry_q))
    else $error("stack pushed or moved without a call");

  // the dead cycle drops the presented word entirely
  chk_flush_drops: assert property (
    s_q.fsm == bbc_pkg::st_flush |=> !file_we_q && !stack_push_q && !retire_q
      && !flush_q && $stable(pc_q))
    else $error("word in the flush cycle was not dropped");

  chk_flush_single: assert property (
    flush_q |-> s_q.fsm == bbc_pkg::st_flush)
    else $error("flush pulse outside the flush state");

  chk_state_onehot: assert property (
    $onehot(s_q.fsm))
    else $error("execution state not one-hot");

  // every accepted word retires one cycle later
  chk_retire_follows: assert property (
    accept |=> retire_q)
    else $error("accepted instruction did not retire");

  // with nothing taken, the pc and the pulses stand still
  chk_idle_holds: assert property (
    !accept |=> $stable(pc_q) && !retire_q && !file_we_q)
    else $error("pc or pulses moved with nothing taken");

  // main scenarios reached
  cov_skip_taken: cover property (take_skz && !bit_val ##1 flush_q);
  cov_call: cover property (take_call ##2 accept);
  cov_back_branch: cover property (take_bra && rel_lit[`BBC_REL_W-1]);
  cov_set_then_clr: cover property (take_set ##1 take_clr);
  cov_skip_one_taken: cover property (take_sko && bit_val ##1 flush_q);

endmodule : bbc_exec

// file: tb/bbc_exec_bench.sv
// self-checking bench for the bit, branch and call execution slice
`timescale 1ns/1ns
`include "bbc_defines.svh"
module bbc_exec_bench;
  // ==========================================================
  // stimulus signals and design instance
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  bbc_pkg::bbc_op_t instr_op = bbc_pkg::op_none;
  logic [6:0] file_addr = 7'h00;
  logic [2:0] bit_sel = 3'h0;
  logic [7:0] file_rdata = 8'h00, acc = 8'h00, page_latch_reg = 8'h00;
  logic [8:0] rel_lit = 9'h000;
  logic [10:0] call_lit = 11'h000;
  logic [14:0] pc_q, stack_top_entry_q, epc, etos;
  logic [6:0] file_waddr_q;
  logic [7:0] file_wdata_q;
  logic file_we_q, stack_push_q, flush_q, retire_q, eflush;
  integer fails = 0, cmp_count = 0, seed = 32'he317, i;
  bbc_exec bbc_exec_i (.clock(clock), .rst(rst), .instr_valid(instr_valid),
    .instr_op(instr_op), .file_addr(file_addr), .bit_sel(bit_sel), .file_rdata(file_rdata),
    .rel_lit(rel_lit), .call_lit(call_lit), .acc(acc), .page_latch_reg(page_latch_reg),
    .pc_q(pc_q), .file_we_q(file_we_q), .file_waddr_q(file_waddr_q),
    .file_wdata_q(file_wdata_q), .stack_push_q(stack_push_q),
    .stack_top_entry_q(stack_top_entry_q), .flush_q(flush_q), .retire_q(retire_q));
  // clock inversion every half period
  always #25 clock = ~clock;
  // ==========================================================
  // compares, expectations and closing
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask : chk_bit
  task automatic results;
    $display("comparisons=%0d mismatches=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  // target of an accepted instruction, wrapping in the 15-bit counter
  function automatic logic [14:0] next_pc(input bbc_pkg::bbc_op_t op, input logic bv,
    input logic [8:0] rl, input logic [10:0] cl, input logic [7:0] a, input logic [7:0] pl,
    input logic [14:0] pc);
    case (op)
      bbc_pkg::rel_jump_literal_op: return pc + 15'h0001 + {{6{rl[8]}}, rl};
      bbc_pkg::rel_jump_acc_op: return pc + 15'h0001 + {7'h00, a};
      bbc_pkg::test_skip_if_zero_op: return pc + (bv ? 15'h0001 : 15'h0002);
      bbc_pkg::test_skip_if_one_op: return pc + (bv ? 15'h0002 : 15'h0001);
      bbc_pkg::call_op: return {pl[6:3], cl};
      default: return pc + 15'h0001;
    endcase
  endfunction : next_pc
  // drive one slot, let an edge pass, then check the outputs, write address and data only on a write
  task automatic issue(input logic v, input bbc_pkg::bbc_op_t op, input logic [6:0] fa,
    input logic [2:0] b, input logic [7:0] rd, input logic [8:0] rl, input logic [10:0] cl,
    input logic [7:0] a, input logic [7:0] pl);
    logic tk, we, fl;
    logic [7:0] wd;
    logic [14:0] np;
    instr_valid = v; instr_op = op; file_addr = fa; bit_sel = b; file_rdata = rd;
    rel_lit = rl; call_lit = cl; acc = a; page_latch_reg = pl;
    tk = v && !eflush;
    we = tk && (op == bbc_pkg::bit_clear_op || op == bbc_pkg::bit_set_op);
    wd = (op == bbc_pkg::bit_set_op) ? (rd | (8'h01 << b)) : (rd & ~(8'h01 << b));
    fl = tk && (op inside {bbc_pkg::rel_jump_literal_op, bbc_pkg::rel_jump_acc_op,
      bbc_pkg::call_op} || (op == bbc_pkg::test_skip_if_zero_op && !rd[b]) ||
      (op == bbc_pkg::test_skip_if_one_op && rd[b]));
    np = tk ? next_pc(op, rd[b], rl, cl, a, pl, epc) : epc;
    if (tk && op == bbc_pkg::call_op) etos = epc + 15'h0001;
    @(posedge clock);
    #1;
    chk_word({1'b0, pc_q}, {1'b0, np});
    chk_bit(file_we_q, we);
    if (we) chk_word({1'b0, file_waddr_q, file_wdata_q}, {1'b0, fa, wd});
    chk_bit(stack_push_q, tk && op == bbc_pkg::call_op);
    chk_word({1'b0, stack_top_entry_q}, {1'b0, etos});
    chk_bit(flush_q, fl);
    chk_bit(retire_q, tk);
    epc = np;
    eflush = fl;
  endtask : issue
  // hold reset for five cycles, pc, flush and stack entry must sit at zero
  task automatic do_reset;
    rst = 1'b1;
    instr_valid = 1'b0;
    repeat (5) @(posedge clock);
    #1;
    chk_word({pc_q, flush_q}, 16'h0000);
    chk_word({1'b0, stack_top_entry_q}, 16'h0000);
    rst = 1'b0;
    epc = 15'h0000; etos = 15'h0000; eflush = 1'b0;
  endtask : do_reset
  // ==========================================================
  // watchdog and main sequence
  initial begin
    #(50 * 5000);
    fails++;
    results();
  end
  initial begin
    do_reset();
    issue(1, bbc_pkg::bit_clear_op, 7'h7f, 3'h7, 8'hff, 0, 0, 0, 0);
    issue(1, bbc_pkg::bit_set_op, 7'h00, 3'h0, 8'h00, 0, 0, 0, 0);
    issue(1, bbc_pkg::call_op, 7'h01, 3'h0, 8'h00, 0, 11'h7ff, 0, 8'h78);
    issue(1, bbc_pkg::bit_set_op, 7'h05, 3'h3, 8'h00, 0, 0, 0, 0);
    issue(1, bbc_pkg::rel_jump_literal_op, 0, 0, 0, 9'h000, 0, 0, 0);
    issue(1, bbc_pkg::op_none, 0, 0, 0, 0, 0, 0, 0);
    issue(1, bbc_pkg::rel_jump_literal_op, 0, 0, 0, 9'h100, 0, 0, 0);
    issue(1, bbc_pkg::op_none, 0, 0, 0, 0, 0, 0, 0);
    issue(1, bbc_pkg::rel_jump_literal_op, 0, 0, 0, 9'h0ff, 0, 0, 0);
    issue(0, bbc_pkg::op_none, 0, 0, 0, 0, 0, 0, 0);
    issue(1, bbc_pkg::rel_jump_acc_op, 0, 0, 0, 0, 0, 8'hff, 0);
    issue(1, bbc_pkg::op_none, 0, 0, 0, 0, 0, 0, 0);
    issue(1, bbc_pkg::test_skip_if_zero_op, 0, 3'h0, 8'h01, 0, 0, 0, 0);
    issue(1, bbc_pkg::test_skip_if_zero_op, 0, 3'h7, 8'h7f, 0, 0, 0, 0);
    issue(0, bbc_pkg::op_none, 0, 0, 0, 0, 0, 0, 0);
    issue(1, bbc_pkg::test_skip_if_one_op, 0, 3'h0, 8'h01, 0, 0, 0, 0);
    issue(1, bbc_pkg::test_skip_if_one_op, 0, 3'h4, 8'hef, 0, 0, 0, 0);
    issue(1, bbc_pkg::test_skip_if_one_op, 0, 3'h4, 8'hef, 0, 0, 0, 0);
    do_reset();
    // random traffic, mostly valid, every code drawn
    for (i = 0; i < 400; i++) begin
      issue(($random(seed) & 7) != 0, bbc_pkg::bbc_op_t'($random(seed) & 7),
        7'($random(seed)), 3'($random(seed)), 8'($random(seed)), 9'($random(seed)),
        11'($random(seed)), 8'($random(seed)), 8'($random(seed)));
    end
    results();
  end
endmodule : bbc_exec_bench
